//--- verilog/port_ctrl_pkg.sv
package port_ctrl_pkg;
	localparam int NUM_PORTS = 12;
	localparam int ADDR_W = 14;
	localparam int CLK_PERIOD_NS = 100;

	// Register addresses
	localparam logic [13:0] ADDR_OUT_A_LOW = 14'h0e08;
	localparam logic [13:0] ADDR_OUT_A_HIGH = 14'h0e09;
	localparam logic [13:0] ADDR_OUT_B_LOW = 14'h0e0a;
	localparam logic [13:0] ADDR_OUT_B_HIGH = 14'h0e0b;
	localparam logic [13:0] ADDR_PIN_SEL_LOW = 14'h0e10;
	localparam logic [13:0] ADDR_PIN_SEL_HIGH = 14'h0e11;
	localparam logic [13:0] ADDR_MODE_BASE = 14'h0e80;
	localparam logic [13:0] ADDR_IRQ_BASE = 14'h0e90;

	// Mode register fields
	localparam int MODE_FRAMER_SKIP = 7;
	localparam int MODE_DELIN_SKIP = 6;
	localparam int MODE_TXCLK_HI = 5;
	localparam int MODE_TXCLK_LO = 4;
	localparam int MODE_OUTA_HI = 3;
	localparam int MODE_OUTA_LO = 2;
	localparam int MODE_OUTB = 1;
	localparam int MODE_HOLD_RESET = 0;
	localparam logic [7:0] MODE_RESET = 8'h00;
	// Fields that only change while the framer channel is inactive
	localparam logic [7:0] MODE_STATIC_MASK = 8'hf0;

	// Interrupt control/status fields
	localparam int IRQ_FRAMER_EN = 7;
	localparam int IRQ_DELIN_EN = 6;
	localparam int IRQ_LINE_EN = 5;
	localparam int IRQ_CHAN_ACTIVE = 4;
	localparam int IRQ_FRAMER_FLAG = 3;
	localparam int IRQ_DELIN_FLAG = 2;
	localparam int IRQ_LINE_FLAG = 1;
	localparam logic [3:0] IRQ_CTRL_RESET = 4'h0;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	typedef enum logic [1:0] {
		TXCLK_SHARED_REF = 2'h0,
		TXCLK_SLICE_TX = 2'h1,
		TXCLK_SLICE_RX = 2'h2,
		TXCLK_RESERVED = 2'h3
	} tx_clk_sel_t;

	typedef enum logic [1:0] {
		OUTA_CELL_LOSS = 2'h0,
		OUTA_FRAME_MISALIGN = 2'h1,
		OUTA_YELLOW = 2'h2,
		OUTA_REG_BIT = 2'h3
	} out_a_sel_t;
endpackage : port_ctrl_pkg

//--- verilog/slice_pins.sv
`timescale 1ns/1ps
`default_nettype none
module slice_pins (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Settings
	input wire logic [7:0] modeQ,
	input wire logic [2:0] irqEnable,
	input wire logic pinSelect,
	input wire logic outABit,
	input wire logic outBBit,
	input wire logic txSyncOutputSel,
	input wire logic txSyncInputSel,
	// Slice status
	input wire logic cellDelineationLoss,
	input wire logic frameMisalignment,
	input wire logic yellowAlarm,
	input wire logic extChipSelect,
	input wire logic framerEvent,
	input wire logic delineatorEvent,
	input wire logic rxSyncFromFramer,
	input wire logic txSyncFromFramer,
	input wire logic [2:0] flagClear,
	// Pins
	input wire logic auxInA,
	input wire logic auxInB,
	output logic auxAOut,
	output logic auxAOe,
	output logic auxBOut,
	output logic auxBOe,
	output logic auxOutA,
	output logic auxOutB,
	// To core
	output logic txSyncToFramer,
	output logic [2:0] flagsQ,
	output logic irqRequest
);
	logic [2:0] setEvt;
	port_ctrl_pkg::out_a_sel_t outASel;

	assign outASel = port_ctrl_pkg::out_a_sel_t'(
		modeQ[port_ctrl_pkg::MODE_OUTA_HI:port_ctrl_pkg::MODE_OUTA_LO]);

	// Line irq input is active low and only meaningful while the pin is an input
	assign setEvt = {framerEvent, delineatorEvent, ~auxInA & ~pinSelect}; // [R13] [R14] [R15]

	// Set wins over a same-cycle clear
	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
			flagsQ <= 3'h0;
		else
			flagsQ <= setEvt | (flagsQ & ~flagClear); // [R13] [R14] [R15]

	assign irqRequest = |(flagsQ & irqEnable); // [R9] [R10] [R11]

	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			auxOutA <= 1'b0;
			auxOutB <= 1'b0;
		end
		else
		begin
			unique case (outASel)
				port_ctrl_pkg::OUTA_CELL_LOSS: auxOutA <= cellDelineationLoss; // [R6]
				port_ctrl_pkg::OUTA_FRAME_MISALIGN: auxOutA <= frameMisalignment; // [R6]
				port_ctrl_pkg::OUTA_YELLOW: auxOutA <= yellowAlarm; // [R6]
				port_ctrl_pkg::OUTA_REG_BIT: auxOutA <= outABit; // [R6] [R19]
			endcase
			auxOutB <= modeQ[port_ctrl_pkg::MODE_OUTB] ? outBBit : extChipSelect; // [R7]
		end

	// Frame-sync pin roles
	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			auxAOut <= 1'b0;
			auxAOe <= 1'b0;
			auxBOut <= 1'b0;
			auxBOe <= 1'b0;
			txSyncToFramer <= 1'b0;
		end
		else
		begin
			auxAOut <= rxSyncFromFramer;
			auxAOe <= pinSelect; // [R1] [R18]
			auxBOut <= txSyncFromFramer;
			auxBOe <= pinSelect & txSyncOutputSel; // [R2]
			txSyncToFramer <= pinSelect & txSyncInputSel & auxInB; // [R2]
		end

	outa_reg_a: assert property (@(posedge clk) disable iff (!nrst)
		modeQ[3:2] == 2'h3 |=> auxOutA == $past(outABit)) // [R19]
		else $error("output A does not follow register bit");
	outb_cs_a: assert property (@(posedge clk) disable iff (!nrst)
		!modeQ[1] |=> auxOutB == $past(extChipSelect)) // [R7]
		else $error("output B does not follow chip select");
	line_flag_a: assert property (@(posedge clk) disable iff (!nrst)
		(!auxInA && !pinSelect) |=> flagsQ[0]) // [R15]
		else $error("line flag not set");
	framer_flag_a: assert property (@(posedge clk) disable iff (!nrst)
		framerEvent && flagClear[2] |=> flagsQ[2]) // [R13]
		else $error("framer event lost on clear");
	sync_pin_a: assert property (@(posedge clk) disable iff (!nrst)
		!pinSelect |=> !auxAOe && !auxBOe) // [R1]
		else $error("frame sync pin driven while input");
endmodule : slice_pins
`default_nettype wire

//--- verilog/port_mode_irq_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// [R1] Select bit repurposes ports 8-11 sync pins
// [R2] Feature bits pick transmit sync direction
// [R3] Framer skip routes pins to delineator
// [R4] Delineator skip routes pins to framer
// [R5] Two-bit transmit clock source select
// [R6] Output A source select, four choices
// [R7] Output B: chip select or register
// [R8] Slice reset bit holds delineator reset
// [R9] Framer enable gates framer interrupts
// [R10] Delineator enable gates delineator interrupts
// [R11] Line enable gates line interrupt
// [R12] Static fields change only while inactive
// [R13] Framer events set framer flag
// [R14] Delineator events set delineator flag
// [R15] Low line input sets line flag
// [R16] Interrupt enables reset to zero
// [R17] Twelve mode registers, reset zero
// [R18] Low-byte select for ports 0-7
// [R19] Register bit appears when selected
// [R20] Host irq low on enabled flag
module port_mode_irq_ctrl (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Host register port
	input wire logic hostCsN,
	input wire logic hostWrN,
	input wire logic hostOeN,
	input wire logic [13:0] hostAddr,
	input wire logic [7:0] hostDataIn,
	output logic [7:0] hostDataOut,
	output logic hostDataOe,
	output logic hostAckOut,
	output logic hostAckOe,
	output logic host_irq_n,
	// Feature control two
	input wire logic txSyncOutputSel,
	input wire logic txSyncInputSel,
	// Slice status
	input wire logic [11:0] cellDelineationLoss,
	input wire logic [11:0] frameMisalignment,
	input wire logic [11:0] yellowAlarm,
	input wire logic [11:0] extChipSelect,
	input wire logic [11:0] framerEvent,
	input wire logic [11:0] delineatorEvent,
	input wire logic [11:0] rxSyncFromFramer,
	input wire logic [11:0] txSyncFromFramer,
	// Auxiliary pins
	input wire logic [11:0] auxInputBankA,
	input wire logic [11:0] auxInputBankB,
	output logic [11:0] auxInputBankAOut,
	output logic [11:0] auxInputBankAOe,
	output logic [11:0] auxInputBankBOut,
	output logic [11:0] auxInputBankBOe,
	output logic [11:0] auxOutputA,
	output logic [11:0] auxOutputB,
	// Slice controls
	output logic [11:0] txSyncToFramer,
	output logic [11:0] framerSkip,
	output logic [11:0] delineatorSkip,
	output logic [23:0] txClockSourceSel,
	output logic [11:0] sliceHoldReset,
	output logic [11:0] framerChannelActive
);
	localparam int NP = port_ctrl_pkg::NUM_PORTS;

	logic [7:0] modeQ [NP];
	logic [3:0] irqCtrlQ [NP];
	logic [2:0] flagsQ [NP];
	logic [NP-1:0] irqRequest;
	logic [NP-1:0] pinSelQ;
	logic [NP-1:0] outAQ;
	logic [NP-1:0] outBQ;
	logic csPrevQ;
	logic accessStart;
	logic writeStrobe;
	logic [7:0] readData;

	// Slot index of an address inside a twelve-register bank, or NP when outside
	function automatic logic [4:0] bankSlot(input logic [13:0] addr, input logic [13:0] base);
		logic [13:0] delta;
		delta = addr - base;
		if (addr >= base && delta < 14'(NP))
			bankSlot = delta[4:0];
		else
			bankSlot = 5'(NP);
	endfunction : bankSlot

	// Reserved code 11 falls back to the shared reference
	function automatic logic [1:0] clockSource(input logic [7:0] mode);
		logic [1:0] sel;
		sel = mode[port_ctrl_pkg::MODE_TXCLK_HI:port_ctrl_pkg::MODE_TXCLK_LO];
		if (port_ctrl_pkg::tx_clk_sel_t'(sel) == port_ctrl_pkg::TXCLK_RESERVED)
			clockSource = port_ctrl_pkg::TXCLK_SHARED_REF;
		else
			clockSource = sel;
	endfunction : clockSource

	// Access begins on the first sampled low of chip select
	assign accessStart = !hostCsN && csPrevQ;
	assign writeStrobe = accessStart && !hostWrN;

	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
			csPrevQ <= 1'b1;
		else
			csPrevQ <= hostCsN;

	// Twelve-bit registers split over low and high bytes
	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			pinSelQ <= '0;
			outAQ <= '0;
			outBQ <= '0;
		end
		else if (writeStrobe)
		begin
			unique case (hostAddr)
				port_ctrl_pkg::ADDR_PIN_SEL_LOW: pinSelQ[7:0] <= hostDataIn; // [R18]
				port_ctrl_pkg::ADDR_PIN_SEL_HIGH: pinSelQ[11:8] <= hostDataIn[3:0]; // [R1]
				port_ctrl_pkg::ADDR_OUT_A_LOW: outAQ[7:0] <= hostDataIn;
				port_ctrl_pkg::ADDR_OUT_A_HIGH: outAQ[11:8] <= hostDataIn[3:0];
				port_ctrl_pkg::ADDR_OUT_B_LOW: outBQ[7:0] <= hostDataIn;
				port_ctrl_pkg::ADDR_OUT_B_HIGH: outBQ[11:8] <= hostDataIn[3:0];
				default: ;
			endcase
		end

	genvar gi;
	generate
		for (gi = 0; gi < NP; gi++)
		begin : g_port
			logic [2:0] flagClear;
			logic modeHit;
			logic irqHit;

			assign modeHit = writeStrobe &&
				bankSlot(hostAddr, port_ctrl_pkg::ADDR_MODE_BASE) == 5'(gi);
			assign irqHit = writeStrobe &&
				bankSlot(hostAddr, port_ctrl_pkg::ADDR_IRQ_BASE) == 5'(gi);
			// Flags clear by writing one
			assign flagClear = irqHit ? hostDataIn[3:1] : 3'h0;

			// Bypass and clock fields would glitch a running framer, so writes leave them unchanged while active
			always_ff @(posedge clk or negedge nrst)
				if (!nrst)
					modeQ[gi] <= port_ctrl_pkg::MODE_RESET; // [R17]
				else if (modeHit)
				begin
					if (irqCtrlQ[gi][0])
						modeQ[gi] <= (modeQ[gi] & port_ctrl_pkg::MODE_STATIC_MASK) |
							(hostDataIn & ~port_ctrl_pkg::MODE_STATIC_MASK); // [R12]
					else
						modeQ[gi] <= hostDataIn; // [R17]
				end

			// Held as {framer en, delineator en, line en, channel active}
			always_ff @(posedge clk or negedge nrst)
				if (!nrst)
					irqCtrlQ[gi] <= port_ctrl_pkg::IRQ_CTRL_RESET; // [R16]
				else if (irqHit)
					irqCtrlQ[gi] <= hostDataIn[7:4];

			always_ff @(posedge clk or negedge nrst)
				if (!nrst)
				begin
					framerSkip[gi] <= 1'b0;
					delineatorSkip[gi] <= 1'b0;
					txClockSourceSel[2*gi +: 2] <= 2'h0;
					sliceHoldReset[gi] <= 1'b0;
					framerChannelActive[gi] <= 1'b0;
				end
				else
				begin
					framerSkip[gi] <= modeQ[gi][port_ctrl_pkg::MODE_FRAMER_SKIP]; // [R3]
					delineatorSkip[gi] <= modeQ[gi][port_ctrl_pkg::MODE_DELIN_SKIP]; // [R4]
					txClockSourceSel[2*gi +: 2] <= clockSource(modeQ[gi]); // [R5]
					sliceHoldReset[gi] <= modeQ[gi][port_ctrl_pkg::MODE_HOLD_RESET]; // [R8]
					framerChannelActive[gi] <= irqCtrlQ[gi][0]; // [R12]
				end

			slice_pins u_slice (
				.clk(clk),
				.nrst(nrst),
				.modeQ(modeQ[gi]),
				.irqEnable(irqCtrlQ[gi][3:1]),
				.pinSelect(pinSelQ[gi]),
				.outABit(outAQ[gi]),
				.outBBit(outBQ[gi]),
				.txSyncOutputSel(txSyncOutputSel),
				.txSyncInputSel(txSyncInputSel),
				.cellDelineationLoss(cellDelineationLoss[gi]),
				.frameMisalignment(frameMisalignment[gi]),
				.yellowAlarm(yellowAlarm[gi]),
				.extChipSelect(extChipSelect[gi]),
				.framerEvent(framerEvent[gi]),
				.delineatorEvent(delineatorEvent[gi]),
				.rxSyncFromFramer(rxSyncFromFramer[gi]),
				.txSyncFromFramer(txSyncFromFramer[gi]),
				.flagClear(flagClear),
				.auxInA(auxInputBankA[gi]),
				.auxInB(auxInputBankB[gi]),
				.auxAOut(auxInputBankAOut[gi]),
				.auxAOe(auxInputBankAOe[gi]),
				.auxBOut(auxInputBankBOut[gi]),
				.auxBOe(auxInputBankBOe[gi]),
				.auxOutA(auxOutputA[gi]),
				.auxOutB(auxOutputB[gi]),
				.txSyncToFramer(txSyncToFramer[gi]),
				.flagsQ(flagsQ[gi]),
				.irqRequest(irqRequest[gi])
			);

			hold_reset_a: assert property (@(posedge clk) disable iff (!nrst)
				modeQ[gi][0] |=> sliceHoldReset[gi]) // [R8]
				else $error("delineator not held in reset");
			static_lock_a: assert property (@(posedge clk) disable iff (!nrst)
				modeHit && irqCtrlQ[gi][0] |=> modeQ[gi][7:4] == $past(modeQ[gi][7:4])) // [R12]
				else $error("static field changed while active");
		end
	endgenerate

	// Read mux
	always_comb
	begin
		logic [4:0] ms;
		logic [4:0] is;
		ms = bankSlot(hostAddr, port_ctrl_pkg::ADDR_MODE_BASE);
		is = bankSlot(hostAddr, port_ctrl_pkg::ADDR_IRQ_BASE);
		readData = port_ctrl_pkg::UNMAPPED_READ;
		if (ms < 5'(NP))
			readData = modeQ[ms[3:0]];
		else if (is < 5'(NP))
			readData = {irqCtrlQ[is[3:0]], flagsQ[is[3:0]], 1'b0};
		else
			unique case (hostAddr)
				port_ctrl_pkg::ADDR_PIN_SEL_LOW: readData = pinSelQ[7:0];
				port_ctrl_pkg::ADDR_PIN_SEL_HIGH: readData = {4'h0, pinSelQ[11:8]};
				port_ctrl_pkg::ADDR_OUT_A_LOW: readData = outAQ[7:0];
				port_ctrl_pkg::ADDR_OUT_A_HIGH: readData = {4'h0, outAQ[11:8]};
				port_ctrl_pkg::ADDR_OUT_B_LOW: readData = outBQ[7:0];
				port_ctrl_pkg::ADDR_OUT_B_HIGH: readData = {4'h0, outBQ[11:8]};
				default: readData = port_ctrl_pkg::UNMAPPED_READ;
			endcase
	end

	// Data and acknowledge held until chip select rises
	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			hostDataOut <= port_ctrl_pkg::BYTE_RESET;
			hostDataOe <= 1'b0;
			hostAckOut <= 1'b0;
			hostAckOe <= 1'b0;
		end
		else
		begin
			if (accessStart && hostWrN)
				hostDataOut <= readData;
			hostDataOe <= !hostCsN && !hostOeN && hostWrN && !accessStart;
			hostAckOut <= !hostCsN && !accessStart;
			hostAckOe <= !hostCsN;
		end

	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
			host_irq_n <= 1'b1;
		else
			host_irq_n <= ~|irqRequest; // [R9] [R10] [R11] [R20]

	host_irq_a: assert property (@(posedge clk) disable iff (!nrst)
		|irqRequest |=> !host_irq_n) // [R20]
		else $error("host interrupt not asserted");
	irq_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
		!(|irqRequest) |=> host_irq_n) // [R9]
		else $error("host interrupt asserted without enabled flag");
	ack_timing_a: assert property (@(posedge clk) disable iff (!nrst)
		accessStart ##1 !hostCsN |=> hostAckOut)
		else $error("acknowledge missing");
endmodule : port_mode_irq_ctrl
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk, nrst, hostCsN, hostWrN, hostOeN, txSyncOutputSel, txSyncInputSel;
	logic [13:0] hostAddr;
	logic [7:0] hostDataIn, hostDataOut, q, v;
	logic hostDataOe, hostAckOut, hostAckOe, host_irq_n;
	logic [11:0] cdl, fm, ya, ecs, fev, dev, rxs, txs, lineDrv, bDrv, selM, outAM, outBM;
	logic [11:0] aOut, aOe, bOut, bOe, auxOutputA, auxOutputB, txSyncToFramer;
	logic [11:0] framerSkip, delineatorSkip, sliceHoldReset, framerChannelActive;
	logic [23:0] txClockSourceSel;
	logic [7:0] modeM [12];
	int fails, checked, cycles, p;
	int seed = 32'h737dabf3;
	// Pins resolve from the design's enables; released line pins idle high, released bank B pins take bDrv
	wire logic [11:0] aPin;
	wire logic [11:0] bPin;
	assign aPin = (aOe & aOut) | (~aOe & lineDrv);
	assign bPin = (bOe & bOut) | (~bOe & bDrv);

	port_mode_irq_ctrl i_dut (.clk(clk), .nrst(nrst), .hostCsN(hostCsN), .hostWrN(hostWrN),
		.hostOeN(hostOeN), .hostAddr(hostAddr), .hostDataIn(hostDataIn),
		.hostDataOut(hostDataOut), .hostDataOe(hostDataOe), .hostAckOut(hostAckOut),
		.hostAckOe(hostAckOe), .host_irq_n(host_irq_n), .txSyncOutputSel(txSyncOutputSel),
		.txSyncInputSel(txSyncInputSel), .cellDelineationLoss(cdl), .frameMisalignment(fm),
		.yellowAlarm(ya), .extChipSelect(ecs), .framerEvent(fev), .delineatorEvent(dev),
		.rxSyncFromFramer(rxs), .txSyncFromFramer(txs), .auxInputBankA(aPin),
		.auxInputBankB(bPin), .auxInputBankAOut(aOut), .auxInputBankAOe(aOe),
		.auxInputBankBOut(bOut), .auxInputBankBOe(bOe), .auxOutputA(auxOutputA),
		.auxOutputB(auxOutputB), .txSyncToFramer(txSyncToFramer), .framerSkip(framerSkip),
		.delineatorSkip(delineatorSkip), .txClockSourceSel(txClockSourceSel),
		.sliceHoldReset(sliceHoldReset), .framerChannelActive(framerChannelActive));

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic end_sim;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim

	// Ceiling well above the nine hundred or so cycles the run needs
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			fails = fails + 1;
			end_sim();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checked = checked + 1;
		if (got !== exp)
		begin
			fails = fails + 1;
			$display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
		end
	endtask : chk

	// One access per chip-select low period, released after ack is seen
	task automatic bus(input logic [13:0] a, input logic wr, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		hostCsN <= 1'b0;
		hostWrN <= ~wr;
		hostOeN <= wr;
		hostAddr <= a;
		hostDataIn <= d;
		do
		begin
			@(negedge clk);
			n++;
		end
		while (hostAckOut !== 1'b1 && n < 20);
		chk(n < 20, 1, "ack timeout");
		chk(hostAckOe, 1'b1, "ack drive");
		q = hostDataOut;
		if (!wr)
		begin
			@(negedge clk);
			chk(hostDataOe, 1'b1, "read drive");
		end
		@(posedge clk);
		hostCsN <= 1'b1;
		hostOeN <= 1'b1;
		hostWrN <= 1'b1;
	endtask : bus

	task automatic rd(input logic [13:0] a, input logic [7:0] exp, input logic [7:0] m);
		bus(a, 1'b0, 8'h00);
		chk(q & m, exp & m, "register read");
	endtask : rd

	task automatic settle;
		@(posedge clk);
		@(posedge clk);
		@(negedge clk);
	endtask : settle

	function automatic logic expA(input int i, input logic [1:0] s);
		case (s)
			2'h0: return cdl[i];
			2'h1: return fm[i];
			2'h2: return ya[i];
			default: return outAM[i];
		endcase
	endfunction : expA

	task automatic check_ports;
		logic [7:0] m;
		for (int i = 0; i < 12; i++)
		begin
			m = modeM[i];
			chk(framerSkip[i], m[7], "framer skip");
			chk(delineatorSkip[i], m[6], "delineator skip");
			chk(txClockSourceSel[2*i+:2], (m[5:4] == 2'h3) ? 2'h0 : m[5:4], "tx clock");
			chk(auxOutputA[i], expA(i, m[3:2]), "output a");
			chk(auxOutputB[i], m[1] ? outBM[i] : ecs[i], "output b");
			chk(sliceHoldReset[i], m[0], "hold reset");
			chk(aOe[i], selM[i], "bank a drive");
			chk(bOe[i], selM[i] & txSyncOutputSel, "bank b drive");
			chk(txSyncToFramer[i], selM[i] & txSyncInputSel & bPin[i], "tx sync in");
			if (selM[i])
				chk(aOut[i], rxs[i], "rx sync out");
			if (selM[i] & txSyncOutputSel)
				chk(bOut[i], txs[i], "tx sync out");
		end
	endtask : check_ports

	initial
	begin
		{nrst, fails, checked, cycles} = '0;
		{hostCsN, hostWrN, hostOeN, hostAddr, hostDataIn} = {3'h7, 14'h0000, 8'h00};
		{txSyncOutputSel, txSyncInputSel, cdl, fm, ya, ecs, fev, dev, rxs, txs} = '0;
		{lineDrv, bDrv} = {12'hfff, 12'hfff};
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		@(negedge clk);
		chk(host_irq_n, 1'b1, "irq idle");
		for (int i = 0; i < 12; i++)
		begin
			rd(14'h0e80 + 14'(i), 8'h00, 8'hff);
			rd(14'h0e90 + 14'(i), 8'h00, 8'hf0);
			modeM[i] = 8'h00;
		end
		rd(14'h0e20, 8'h00, 8'hff);
		for (int r = 0; r < 4; r++)
		begin
			// Fixed corners on the first round, random afterwards
			{outAM, outBM, selM} = (r == 0) ? 36'hfff000f0f : 36'({$random(seed), $random(seed)});
			bus(14'h0e08, 1'b1, outAM[7:0]);
			bus(14'h0e09, 1'b1, {4'h0, outAM[11:8]});
			bus(14'h0e0a, 1'b1, outBM[7:0]);
			bus(14'h0e0b, 1'b1, {4'h0, outBM[11:8]});
			bus(14'h0e10, 1'b1, selM[7:0]);
			bus(14'h0e11, 1'b1, {4'h0, selM[11:8]});
			rd(14'h0e11, {4'h0, selM[11:8]}, 8'h0f);
			for (int i = 0; i < 12; i++)
			begin
				v = (r == 0) ? 8'(i * 8'h15) | 8'h30 : 8'($random(seed));
				modeM[i] = v;
				bus(14'h0e80 + 14'(i), 1'b1, v);
				rd(14'h0e80 + 14'(i), v, 8'hff);
			end
			@(posedge clk);
			{cdl, fm, ya, ecs} <= 48'({$random(seed), $random(seed)});
			{rxs, txs, bDrv} <= 36'({$random(seed), $random(seed)});
			{txSyncOutputSel, txSyncInputSel} <= 2'($random(seed));
			settle();
			check_ports();
		end
		// Static fields locked while the channel is active
		p = 5;
		bus(14'h0e90 + 14'(p), 1'b1, 8'h10);
		bus(14'h0e80 + 14'(p), 1'b1, 8'hff);
		modeM[p] = {modeM[p][7:4], 4'hf};
		rd(14'h0e80 + 14'(p), modeM[p], 8'hff);
		settle();
		chk(framerChannelActive, 12'h020, "channel active");
		check_ports();
		bus(14'h0e90 + 14'(p), 1'b1, 8'h00);
		settle();
		chk(framerChannelActive, 12'h000, "channel idle");
		bus(14'h0e10, 1'b1, 8'h00);
		bus(14'h0e11, 1'b1, 8'h00);
		// A released sync pin can leave a low on the line input for a cycle
		for (int i = 0; i < 12; i++)
			bus(14'h0e90 + 14'(i), 1'b1, 8'h0e);
		// Each source: masked flag, then enabled, then cleared
		for (int k = 0; k < 3; k++)
		begin
			p = int'($unsigned($random(seed)) % 12);
			@(posedge clk);
			if (k == 0) fev[p] <= 1'b1;
			if (k == 1) dev[p] <= 1'b1;
			if (k == 2) lineDrv[p] <= 1'b0;
			@(posedge clk);
			{fev, dev, lineDrv} <= {24'h000000, 12'hfff};
			settle();
			chk(host_irq_n, 1'b1, "masked irq");
			rd(14'h0e90 + 14'(p), 8'h08 >> k, 8'hff);
			bus(14'h0e90 + 14'(p), 1'b1, 8'h80 >> k);
			settle();
			chk(host_irq_n, 1'b0, "enabled irq");
			bus(14'h0e90 + 14'(p), 1'b1, (8'h80 >> k) | (8'h08 >> k));
			settle();
			chk(host_irq_n, 1'b1, "cleared irq");
			bus(14'h0e90 + 14'(p), 1'b1, 8'h00);
		end
		bus(14'h0e20, 1'b1, 8'h5a);
		rd(14'h0e20, 8'h00, 8'hff);
		end_sim();
	end
endmodule : tb_top
`default_nettype wire
